// file: hw/ltc_pkg.sv
// constants, field layout and bus carriers for the lite timebase timer
package ltc_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int LTC_DATA_W = 32;
  localparam int LTC_ADDR_W = 8;

  // ---------------------------------------------------------------
  // register indices as printed; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] LTC_IDX_TB2_CS = 8'h0c;
  localparam logic [7:0] LTC_IDX_RELOAD = 8'h0d;
  localparam logic [7:0] LTC_IDX_CNT2 = 8'h0e;
  localparam logic [7:0] LTC_IDX_TB1_CS = 8'h0f;
  localparam logic [7:0] LTC_IDX_CAPT = 8'h10;
  localparam logic [7:0] LTC_ADR_TB2_CS = 8'(LTC_IDX_TB2_CS * 4);
  localparam logic [7:0] LTC_ADR_RELOAD = 8'(LTC_IDX_RELOAD * 4);
  localparam logic [7:0] LTC_ADR_CNT2 = 8'(LTC_IDX_CNT2 * 4);
  localparam logic [7:0] LTC_ADR_TB1_CS = 8'(LTC_IDX_TB1_CS * 4);
  localparam logic [7:0] LTC_ADR_CAPT = 8'(LTC_IDX_CAPT * 4);

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LTC_TB2_IE_BIT = 1;
  localparam int LTC_TB2_FLAG_BIT = 0;
  localparam int LTC_CAP_IE_BIT = 7;
  localparam int LTC_CAP_FLAG_BIT = 6;
  localparam int LTC_PSEL_BIT = 5;
  localparam int LTC_TB1_IE_BIT = 4;
  localparam int LTC_TB1_FLAG_BIT = 3;
  // index into the snapshot of flags that a read may clear
  localparam int LTC_SEEN_TB2 = 0;
  localparam int LTC_SEEN_TB1 = 1;
  localparam int LTC_SEEN_CAP = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LTC_RST_BYTE = 8'h00;
  localparam logic LTC_RST_BIT = 1'b0;

  // ---------------------------------------------------------------
  // timing: the clock is the oscillator, counters tick at osc / 32
  // ---------------------------------------------------------------
  localparam int LTC_OSC_DIV = 32;
  localparam int LTC_PRESC_W = 5;
  localparam logic [4:0] LTC_PRESC_LAST = 5'(LTC_OSC_DIV - 1);
  localparam int LTC_TB1_SHORT_OSC = 8000;
  localparam int LTC_TB1_LONG_OSC = 16000;
  localparam logic [7:0] LTC_CNT1_LAST =
    8'(LTC_TB1_SHORT_OSC / LTC_OSC_DIV - 1);
  localparam logic [7:0] LTC_CNT2_LAST = 8'hff;

  // ---------------------------------------------------------------
  // apb carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [LTC_ADDR_W-1:0] paddr;
    logic [LTC_DATA_W-1:0] pwdata;
  } ltc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [LTC_DATA_W-1:0] prdata;
  } ltc_apb_rsp_s;

endpackage

// file: hw/ltc_capture_unit.sv
// input capture: pin synchroniser, edge detect, capture value and flag
`timescale 1ns/1ps
`default_nettype none
module ltc_capture_unit
  import ltc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic capture_input_pin,
  input wire logic [7:0] count_in,
  input wire logic clear_read,
  output logic [7:0] captured_field,
  output logic capture_flag
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic pin_edge;
  logic accept;
  logic [7:0] value_ff;
  logic flag_ff;

  // two flops before any logic, third holds last level for edge detect
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= LTC_RST_BIT;
      sync2_ff <= LTC_RST_BIT;
      prev_ff <= LTC_RST_BIT;
    end
    else
    begin
      sync1_ff <= capture_input_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // either edge; a capture pending blocks new ones unless read away now
  assign pin_edge = sync2_ff ^ prev_ff;
  assign accept = pin_edge & (~flag_ff | clear_read);

  // captured value, cleared on reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      value_ff <= LTC_RST_BYTE;
    else if (accept)
      value_ff <= count_in;
  end

  // flag: capture sets, read clears, set wins over clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flag_ff <= LTC_RST_BIT;
    else
      flag_ff <= accept | (flag_ff & ~clear_read);
  end

  assign captured_field = value_ff;
  assign capture_flag = flag_ff;

  capture_latch_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (pin_edge && !flag_ff) |=> (value_ff == $past(count_in)) && flag_ff)
    else $error("capture did not latch counter 1");

  capture_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (flag_ff && !clear_read) |=> $stable(value_ff) && flag_ff)
    else $error("capture value changed while pending");

  // an edge is seen only where the pin itself moved three edges back
  single_edge_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (pin_edge && $past(nrst, 3)) |->
      $past(capture_input_pin, 2) != $past(capture_input_pin, 3))
    else $error("edge seen without a pin change");

endmodule
`default_nettype wire

// file: hw/ltc_timer.sv
// lite timer: fixed timebase, auto-reload timebase and input capture
`timescale 1ns/1ps
`default_nettype none
module ltc_timer
(
  input wire logic clock,
  input wire logic nrst,
  input wire ltc_pkg::ltc_apb_req_s apb_req,
  output ltc_pkg::ltc_apb_rsp_s apb_rsp,
  input wire logic capture_input_pin,
  input wire logic halt_mode,
  output logic irq_period1,
  output logic irq_period2,
  output logic irq_capture
);
  import ltc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [LTC_PRESC_W-1:0] presc_ff;
  logic tick;
  logic [7:0] cnt1_ff;
  logic roll1;
  logic half_ff;
  logic tb1_event;
  logic [7:0] cnt2_ff;
  logic tb2_event;
  logic [7:0] reload_ff;
  logic period1_overflow_flag_ff;
  logic period2_overflow_flag_ff;
  logic period1_irq_enable_ff;
  logic period2_irq_enable_ff;
  logic capture_irq_enable_ff;
  logic period_select_ff;
  logic [7:0] captured_field;
  logic capture_flag;
  logic access;
  logic done;
  logic rd_done;
  logic wr_done;
  logic [2:0] seen_ff;
  logic [2:0] nxt_seen;
  logic clr_tb1;
  logic clr_tb2;
  logic clr_cap;
  logic [7:0] rd_byte;
  logic rd_hit;
  ltc_apb_rsp_s rsp_ff;
  logic irq_p1_ff;
  logic irq_p2_ff;
  logic irq_cap_ff;

  // ---------------------------------------------------------------
  // prescaler and counters
  // ---------------------------------------------------------------

  // osc / 32 tick; halt freezes the whole chain so no period is cut short
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      presc_ff <= '0;
    else if (!halt_mode)
      presc_ff <= (presc_ff == LTC_PRESC_LAST) ? '0 : presc_ff + 1'b1;
  end

  assign tick = !halt_mode && (presc_ff == LTC_PRESC_LAST);

  // counter 1 runs 0 .. f9 and is invisible to software
  assign roll1 = tick && (cnt1_ff == LTC_CNT1_LAST);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt1_ff <= LTC_RST_BYTE;
    else if (roll1)
      cnt1_ff <= LTC_RST_BYTE;
    else if (tick)
      cnt1_ff <= cnt1_ff + 8'h01;
  end

  // long period counts every second roll; cleared in short mode so a
  // switch to long flags on the second roll after it, not the first
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      half_ff <= LTC_RST_BIT;
    else if (roll1)
      half_ff <= period_select_ff ? ~half_ff : LTC_RST_BIT;
  end

  assign tb1_event = roll1 && (!period_select_ff || half_ff);

  // counter 2 reloads from the reload register on the roll from ff
  assign tb2_event = tick && (cnt2_ff == LTC_CNT2_LAST);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt2_ff <= LTC_RST_BYTE;
    else if (tb2_event)
      cnt2_ff <= reload_ff;
    else if (tick)
      cnt2_ff <= cnt2_ff + 8'h01;
  end

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  ltc_capture_unit u_capture
  (
    .clock(clock),
    .nrst(nrst),
    .capture_input_pin(capture_input_pin),
    .count_in(cnt1_ff),
    .clear_read(clr_cap),
    .captured_field(captured_field),
    .capture_flag(capture_flag)
  );

  // ---------------------------------------------------------------
  // apb slave: one wait state so read data come from a flop
  // ---------------------------------------------------------------
  assign access = apb_req.psel && apb_req.penable;
  assign done = access && rsp_ff.pready;
  assign rd_done = done && !apb_req.pwrite;
  assign wr_done = done && apb_req.pwrite;

  // read mux and decode; misaligned or unknown addresses are errors
  always_comb
  begin
    rd_byte = LTC_RST_BYTE;
    rd_hit = 1'b1;
    nxt_seen = 3'b000;
    if (apb_req.paddr == LTC_ADR_TB2_CS)
    begin
      rd_byte[LTC_TB2_IE_BIT] = period2_irq_enable_ff;
      rd_byte[LTC_TB2_FLAG_BIT] = period2_overflow_flag_ff;
      nxt_seen[LTC_SEEN_TB2] = period2_overflow_flag_ff;
    end
    else if (apb_req.paddr == LTC_ADR_RELOAD)
      rd_byte = reload_ff;
    else if (apb_req.paddr == LTC_ADR_CNT2)
      rd_byte = cnt2_ff;
    else if (apb_req.paddr == LTC_ADR_TB1_CS)
    begin
      rd_byte[LTC_CAP_IE_BIT] = capture_irq_enable_ff;
      rd_byte[LTC_CAP_FLAG_BIT] = capture_flag;
      rd_byte[LTC_PSEL_BIT] = period_select_ff;
      rd_byte[LTC_TB1_IE_BIT] = period1_irq_enable_ff;
      rd_byte[LTC_TB1_FLAG_BIT] = period1_overflow_flag_ff;
      nxt_seen[LTC_SEEN_TB1] = period1_overflow_flag_ff;
    end
    else if (apb_req.paddr == LTC_ADR_CAPT)
    begin
      rd_byte = captured_field;
      nxt_seen[LTC_SEEN_CAP] = capture_flag;
    end
    else
      rd_hit = 1'b0;
    if (apb_req.pwrite)
      nxt_seen = 3'b000;
  end

  // answer registered in the first access cycle, held one cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_ff <= '0;
      seen_ff <= 3'b000;
    end
    else if (access && !rsp_ff.pready)
    begin
      rsp_ff.pready <= 1'b1;
      rsp_ff.pslverr <= !rd_hit;
      rsp_ff.prdata <= apb_req.pwrite ? '0 : {24'h000000, rd_byte};
      seen_ff <= nxt_seen;
    end
    else
    begin
      rsp_ff <= '0;
      seen_ff <= 3'b000;
    end
  end

  // only a flag that the read returned as set is cleared by it, so an
  // event between sampling and completion is never lost
  assign clr_tb2 = rd_done && seen_ff[LTC_SEEN_TB2];
  assign clr_tb1 = rd_done && seen_ff[LTC_SEEN_TB1];
  assign clr_cap = rd_done && seen_ff[LTC_SEEN_CAP];

  // ---------------------------------------------------------------
  // software written control; flags and counter ignore writes
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reload_ff <= LTC_RST_BYTE;
      period2_irq_enable_ff <= LTC_RST_BIT;
      capture_irq_enable_ff <= LTC_RST_BIT;
      period_select_ff <= LTC_RST_BIT;
      period1_irq_enable_ff <= LTC_RST_BIT;
    end
    else if (wr_done && !rsp_ff.pslverr)
    begin
      if (apb_req.paddr == LTC_ADR_TB2_CS)
        period2_irq_enable_ff <= apb_req.pwdata[LTC_TB2_IE_BIT];
      else if (apb_req.paddr == LTC_ADR_RELOAD)
        reload_ff <= apb_req.pwdata[7:0];
      else if (apb_req.paddr == LTC_ADR_TB1_CS)
      begin
        capture_irq_enable_ff <= apb_req.pwdata[LTC_CAP_IE_BIT];
        period_select_ff <= apb_req.pwdata[LTC_PSEL_BIT];
        period1_irq_enable_ff <= apb_req.pwdata[LTC_TB1_IE_BIT];
      end
    end
  end

  // event flags: set wins over a clearing read in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      period1_overflow_flag_ff <= LTC_RST_BIT;
      period2_overflow_flag_ff <= LTC_RST_BIT;
    end
    else
    begin
      period1_overflow_flag_ff <= tb1_event
        | (period1_overflow_flag_ff & ~clr_tb1);
      period2_overflow_flag_ff <= tb2_event
        | (period2_overflow_flag_ff & ~clr_tb2);
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests, one per vector, gated by their enables
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_p1_ff <= LTC_RST_BIT;
      irq_p2_ff <= LTC_RST_BIT;
      irq_cap_ff <= LTC_RST_BIT;
    end
    else
    begin
      irq_p1_ff <= period1_overflow_flag_ff & period1_irq_enable_ff;
      irq_p2_ff <= period2_overflow_flag_ff & period2_irq_enable_ff;
      irq_cap_ff <= capture_flag & capture_irq_enable_ff;
    end
  end

  assign irq_period1 = irq_p1_ff;
  assign irq_period2 = irq_p2_ff;
  assign irq_capture = irq_cap_ff;
  assign apb_rsp = rsp_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  irq1_gate_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !$past(period1_irq_enable_ff) |-> !irq_period1)
    else $error("timebase 1 request without enable");

  irq2_follow_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (period2_overflow_flag_ff && period2_irq_enable_ff) |=> irq_period2)
    else $error("timebase 2 request missing");

  reserved_zero_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (rd_done && apb_req.paddr == LTC_ADR_TB2_CS) |->
      rsp_ff.prdata[7:2] == 6'h00)
    else $error("reserved bits read non-zero");

  tb2_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    tb2_event |=> period2_overflow_flag_ff ##1
      (period2_overflow_flag_ff || $past(clr_tb2)))
    else $error("timebase 2 flag not set on overflow");

  flag_write_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (wr_done && !period2_overflow_flag_ff && !tb2_event) |=>
      !period2_overflow_flag_ff)
    else $error("write changed timebase 2 flag");

  reload_load_a: assert property (
    @(posedge clock) disable iff (!nrst)
    tb2_event |=> cnt2_ff == $past(reload_ff))
    else $error("counter 2 did not reload");

  cnt2_readonly_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (wr_done && !tick) |=> $stable(cnt2_ff))
    else $error("write altered counter 2");

  // halt freezes the chain, so an attempt that meets halt is dropped
  cnt1_roll_a: assert property (
    @(posedge clock) disable iff (!nrst || halt_mode)
    roll1 |=> cnt1_ff == 8'h00 ##[31:31] cnt1_ff == 8'h00 ##1
      cnt1_ff == 8'h01)
    else $error("counter 1 roll or rate wrong");

  tb1_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clr_tb1 && !tb1_event) |=> !period1_overflow_flag_ff)
    else $error("timebase 1 flag not cleared by read");

  halt_freeze_a: assert property (
    @(posedge clock) disable iff (!nrst)
    halt_mode |=> $stable(cnt1_ff) && $stable(cnt2_ff))
    else $error("counters moved in halt");

endmodule
`default_nettype wire

// file: testbench/ltc_pin_src.sv
// capture pin source: toggles the pin on request after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module ltc_pin_src
(
  input wire logic clock,
  input wire logic fire,
  input wire logic [3:0] lag,
  output logic pin
);
  // ---------------------------------------------------------------
  // edge generator
  // ---------------------------------------------------------------
  // pin rests low so reset release makes no spurious edge
  initial pin = 1'b0;
  // toggle on a rising edge after the lag; the sync stage takes it next
  always @(posedge clock)
  begin
    if (fire)
    begin
      repeat (lag) @(posedge clock);
      pin <= ~pin;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_lite_timebase_capture_timer.sv
// testbench for the lite timer: apb master, reference model, scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_lite_timebase_capture_timer;
  import ltc_pkg::*;
  localparam logic [7:0] REG_ADR [5] = '{LTC_ADR_TB2_CS, LTC_ADR_RELOAD,
    LTC_ADR_CNT2, LTC_ADR_TB1_CS, LTC_ADR_CAPT};
  logic clock, nrst, halt_mode, fire, pin, irq1, irq2, irqc;
  logic [3:0] lag;
  ltc_apb_req_s req;
  ltc_apb_rsp_s rsp;
  int num_errors = 0;
  int checked = 0;
  int presc, c1, c2, rel, cap;
  bit half, f1, f2, cf, ie1, ie2, capture_irq_enable, psel_m;

  ltc_timer i_dut (.clock(clock), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .capture_input_pin(pin), .halt_mode(halt_mode),
    .irq_period1(irq1), .irq_period2(irq2), .irq_capture(irqc));
  ltc_pin_src i_src (.clock(clock), .fire(fire), .lag(lag), .pin(pin));

  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  // counters tick every 32 clocks unless halted; flags set on rolls
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      {presc, c1, c2, rel, cap} = '0;
      {half, f1, f2, cf, ie1, ie2, capture_irq_enable, psel_m} = '0;
    end
    else if (!halt_mode)
    begin
      presc = (presc + 1) % LTC_OSC_DIV;
      if (presc == 0)
      begin
        if (c1 == 8'hf9)
        begin
          // long period flags only every second roll
          if (!psel_m || half)
            f1 = 1'b1;
          half = psel_m ? !half : 1'b0;
          c1 = 0;
        end
        else
          c1++;
        if (c2 == 8'hff)
        begin
          c2 = rel;
          f2 = 1'b1;
        end
        else
          c2++;
      end
    end
  end

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      LTC_ADR_TB2_CS: return {30'h0, ie2, f2};
      LTC_ADR_RELOAD: return 32'(rel);
      LTC_ADR_CNT2: return 32'(c2);
      LTC_ADR_TB1_CS: return {24'h0, capture_irq_enable, cf, psel_m, ie1, f1, 3'h0};
      LTC_ADR_CAPT: return 32'(cap);
      default: return 32'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer compared with the model; only call while halted
  task automatic acc(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    logic [31:0] ex;
    logic bad;
    int n;
    ex = wr ? 32'h0 : exp_rd(a);
    bad = 1'b1;
    n = 0;
    foreach (REG_ADR[i])
      if (REG_ADR[i] == a)
        bad = 1'b0;
    @(posedge clock);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clock);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.pready !== 1'b1);
    check("pready wait", n, 32'd2);
    check($sformatf("prdata %h", a), rsp.prdata, ex);
    check($sformatf("pslverr %h", a), 32'(rsp.pslverr), 32'(bad));
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    case (a)
      LTC_ADR_TB2_CS: if (wr) ie2 = wd[1]; else f2 = 1'b0;
      LTC_ADR_RELOAD: if (wr) rel = wd[7:0];
      LTC_ADR_TB1_CS:
        if (wr) {capture_irq_enable, psel_m, ie1} = {wd[7], wd[5], wd[4]};
        else f1 = 1'b0;
      LTC_ADR_CAPT: if (!wr) cf = 1'b0;
      default: ;
    endcase
  endtask

  // run n clocks, freeze, then compare requests and registers
  task automatic run_check(input int n);
    halt_mode <= 1'b0;
    repeat (n) @(posedge clock);
    halt_mode <= 1'b1;
    repeat (3) @(posedge clock);
    check("irq_period1", 32'(irq1), 32'(f1 & ie1));
    check("irq_period2", 32'(irq2), 32'(f2 & ie2));
    acc(1'b0, LTC_ADR_CNT2, 32'h0);
    acc(1'b0, LTC_ADR_TB2_CS, 32'h0);
    acc(1'b0, LTC_ADR_TB1_CS, 32'h0);
  endtask

  // one pin edge, counters frozen, so the captured count is exact
  task automatic edge_in(input logic [3:0] l);
    lag <= l;
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (int'(l) + 8) @(posedge clock);
    if (!cf)
    begin
      cf = 1'b1;
      cap = c1;
    end
    check("irq_capture", 32'(irqc), 32'(cf & capture_irq_enable));
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    req = '0;
    nrst = 1'b0;
    halt_mode = 1'b1;
    fire = 1'b0;
    lag = 4'h0;
    void'($urandom(9030));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    acc(1'b0, LTC_ADR_CAPT, 32'h0);
    foreach (REG_ADR[i])
      acc(1'b0, REG_ADR[i], 32'h0);
    acc(1'b0, 8'h44, 32'h0);
    acc(1'b1, 8'h31, 32'hff);
    // all ones except bits 7:2 at LTC_ADR_TB2_CS: reserved, flag and read-only bits must hold
    foreach (REG_ADR[i])
      acc(1'b1, REG_ADR[i], (REG_ADR[i] == LTC_ADR_TB2_CS) ?
        32'hffff_ff03 : 32'hffff_ffff);
    foreach (REG_ADR[i])
      acc(1'b0, REG_ADR[i], 32'h0);
    acc(1'b1, LTC_ADR_TB1_CS, 32'h90);
    acc(1'b1, LTC_ADR_RELOAD, 32'($urandom_range(240, 250)));
    acc(1'b0, LTC_ADR_RELOAD, 32'h0);
    repeat (4)
      run_check($urandom_range(200, 1500));
    repeat (200) @(posedge clock);
    acc(1'b0, LTC_ADR_CNT2, 32'h0);
    run_check(8200);
    acc(1'b1, LTC_ADR_TB2_CS, 32'h0);
    acc(1'b1, LTC_ADR_TB1_CS, 32'hb0);
    run_check(8000);
    run_check(8000);
    edge_in(4'($urandom_range(0, 9)));
    acc(1'b0, LTC_ADR_TB1_CS, 32'h0);
    run_check(500);
    edge_in(4'($urandom_range(0, 9)));
    acc(1'b0, LTC_ADR_CAPT, 32'h0);
    run_check(300);
    edge_in(4'($urandom_range(0, 9)));
    acc(1'b0, LTC_ADR_CAPT, 32'h0);
    repeat (20) @(posedge clock);
    acc(1'b0, LTC_ADR_TB1_CS, 32'h0);
    complete_run();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge clock);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
